// ===== scsc_top.sv
// module: clock source control with apb registers, start-up counter and source arbitration
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - crystal modes count 1024 primary oscillator edges before clock is stable
// - count launches after reset and power-up delay, and on every wake-up
// - execution held while counting unless failure monitor or two-speed enabled
// - with monitor or two-speed enabled, run on internal clock while counting
// - multiplier enabled when fuse or software enable bit is one and source field is 00
// - fuse set makes software multiplier bit ignored
// - secondary 32.768 kHz oscillator selectable at run time as system clock
// - in RC and internal modes second pin is gpio or clock out by fuse
// - internal mode releases primary clock input pin as gpio
// - internal block selected by fuse default or by software source field
// - 16 MHz source built from 500 kHz by loop, feeds postscaler mux
// - 16 MHz source on for its select codes when internal block chosen
// - 500 kHz source on for its select codes when internal block chosen
// - four-bit frequency select picks postscaler output frequency
// - high-frequency ready flag reads one while that source runs
// - high-frequency locked flag shows within two percent
// - high-frequency stable flag shows within half a percent
// - medium-frequency ready flag reads one while that source runs
// - fast start-up oscillator clocks circuits until 16 MHz source is ready
// - source field: 00 fuse, 01 secondary, 1x internal; cleared on reset
// - frequency select loads 0111 after any reset
// - 32 MHz needs internal fuse, source 00, code 1110, multiplier on
module scsc_top
	import scsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  fuse_osc_mode,
	input  wire logic        fuse_multiplier_enable,
	input  wire logic        clock_out_pin_fuse,
	input  wire logic        fuse_power_up_delay_en,
	input  wire logic        fuse_clock_failure_monitor_en,
	input  wire logic        fuse_two_speed_en,
	input  wire logic        power_up_delay_done,
	input  wire logic        sleep_wake,
	input  wire logic        primary_clock_in_pin,
	input  wire logic        hf_running,
	input  wire logic        hf_within_2pct,
	input  wire logic        hf_within_half_pct,
	input  wire logic        mf_running,
	output logic [1:0]       active_source,
	output logic [3:0]       internal_freq_select,
	output logic             multiplier_enable,
	output logic             internal_32mhz,
	output logic             hf_enable,
	output logic             mf_enable,
	output logic             hf_loop_enable,
	output logic             fast_startup_active,
	output logic             hold_execution,
	output logic             run_on_internal,
	output logic             crystal_stable,
	output logic             primary_in_gpio,
	output logic             primary_out_clkout,
	output logic             primary_out_gpio
);
	import scsc_pkg::*;

	// ------------------------------------------------------------
	// pin and oscillator status synchronisers
	// ------------------------------------------------------------
	logic [6:0] async_raw;
	logic [6:0] async_s;
	wire        prim_s;
	wire        wake_s;
	wire        power_up_delay_timer_s;
	wire        hf_ready_s;
	wire        hf_locked_s;
	wire        hf_stable_s;
	wire        mf_ready_s;

	assign async_raw = {primary_clock_in_pin, sleep_wake, power_up_delay_done,
		hf_running, hf_within_2pct, hf_within_half_pct, mf_running};

	scsc_sync #(.W(7)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (async_raw),
		.sync_out (async_s)
	);

	assign prim_s      = async_s[6];
	assign wake_s      = async_s[5];
	assign power_up_delay_timer_s      = async_s[4];
	assign hf_ready_s  = async_s[3];
	assign hf_locked_s = async_s[2];
	assign hf_stable_s = async_s[1];
	assign mf_ready_s  = async_s[0];

	// ------------------------------------------------------------
	// apb register file
	// ------------------------------------------------------------
	logic [1:0]  src_q;
	logic [3:0]  ifs_q;
	logic        soft_mult_q;
	logic [31:0] stat_word;
	logic [31:0] ctrl_word;
	wire         access;
	wire         sel_ctrl;
	wire         sel_stat;
	wire         mapped;
	wire         wr_ctrl;
	wire [31:0]  rd_mux;

	assign access   = psel && penable && !pready;
	assign sel_ctrl = (paddr == CTRL_OFFSET);
	assign sel_stat = (paddr == STAT_OFFSET);
	assign mapped   = sel_ctrl || sel_stat;
	assign wr_ctrl  = access && pwrite && sel_ctrl;
	assign rd_mux   = sel_ctrl ? ctrl_word : (sel_stat ? stat_word : 32'h0000_0000);

	always_comb
	begin
		ctrl_word                               = 32'h0000_0000;
		ctrl_word[CTRL_SRC_LSB +: 2]            = src_q;
		ctrl_word[CTRL_IFS_LSB +: 4]            = ifs_q;
		ctrl_word[CTRL_SOFT_MULT]               = soft_mult_q;
		stat_word                               = 32'h0000_0000;
		stat_word[STAT_HF_STABLE]               = hf_stable_s;
		stat_word[STAT_HF_LOCKED]               = hf_locked_s;
		stat_word[STAT_MF_READY]                = mf_ready_s;
		stat_word[STAT_HF_READY]                = hf_ready_s;
		stat_word[STAT_XTAL_DONE]               = crystal_stable;
	end

	// one wait state: pready rises in the cycle after the access phase starts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= access;
			pslverr <= access && !mapped;
			if (access && !pwrite)
				prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_q       <= CTRL_RESET[CTRL_SRC_LSB +: 2];
			ifs_q       <= CTRL_RESET[CTRL_IFS_LSB +: 4];
			soft_mult_q <= CTRL_RESET[CTRL_SOFT_MULT];
		end
		else if (wr_ctrl)
		begin
			src_q       <= pwdata[CTRL_SRC_LSB +: 2];
			ifs_q       <= pwdata[CTRL_IFS_LSB +: 4];
			soft_mult_q <= pwdata[CTRL_SOFT_MULT];
		end
	end

	// ------------------------------------------------------------
	// crystal start-up sequencing
	// ------------------------------------------------------------
	logic  prim_d_q;
	logic  wake_d_q;
	logic  launched_q;
	wire   osc_edge;
	wire   wake_rise;
	wire   crystal_mode;
	wire   power_up_delay_timer_ok;
	wire   launch;
	wire   su_busy;
	wire   su_done;
	wire   bypass_hold;

	assign crystal_mode = (fuse_osc_mode == MODE_WATCH) || (fuse_osc_mode == MODE_MEDIUM)
		|| (fuse_osc_mode == MODE_HIGH);
	assign osc_edge     = prim_s && !prim_d_q;
	assign wake_rise    = wake_s && !wake_d_q;
	assign power_up_delay_timer_ok      = !fuse_power_up_delay_en || power_up_delay_timer_s;
	assign launch       = crystal_mode && ((!launched_q && power_up_delay_timer_ok) || wake_rise);
	assign bypass_hold  = fuse_clock_failure_monitor_en || fuse_two_speed_en;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prim_d_q   <= 1'b0;
			wake_d_q   <= 1'b0;
			launched_q <= 1'b0;
		end
		else
		begin
			prim_d_q   <= prim_s;
			wake_d_q   <= wake_s;
			launched_q <= launched_q || launch;
		end
	end

	scsc_startup u_startup (
		.pclk     (pclk),
		.presetn  (presetn),
		.launch   (launch),
		.osc_edge (osc_edge),
		.busy_q   (su_busy),
		.done_q   (su_done)
	);

	// ------------------------------------------------------------
	// source arbitration
	// ------------------------------------------------------------
	wire  internal_fuse;
	wire  internal_sel;
	wire  mult_req;
	wire  mult_on;
	wire  hf_on;
	wire  mf_on;
	wire  rc_or_int;
	wire  want_32;
	wire  hold_d;
	wire  run_int_d;

	assign internal_fuse = (fuse_osc_mode == MODE_INTERNAL);
	assign internal_sel  = (internal_fuse && src_q == SRC_FUSE) || src_q[1];
	assign mult_req      = fuse_multiplier_enable || soft_mult_q;
	// multiplier only follows the fuse-defined source; never the internal block via 1x
	assign mult_on       = mult_req && (src_q == SRC_FUSE);
	assign want_32       = internal_fuse && src_q == SRC_FUSE && ifs_q == IFS_32MHZ && mult_req;
	assign hf_on         = IFS_HF_CODES[ifs_q] && internal_sel;
	assign mf_on         = IFS_MF_CODES[ifs_q] && internal_sel;
	assign rc_or_int     = (fuse_osc_mode == MODE_RC) || internal_fuse;
	assign hold_d        = su_busy && !bypass_hold;
	assign run_int_d     = su_busy && bypass_hold;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			active_source        <= SRC_FUSE;
			internal_freq_select <= IFS_RESET;
			multiplier_enable    <= 1'b0;
			internal_32mhz       <= 1'b0;
			hf_enable            <= 1'b0;
			mf_enable            <= 1'b0;
			hf_loop_enable       <= 1'b0;
			fast_startup_active  <= 1'b0;
			hold_execution       <= 1'b0;
			run_on_internal      <= 1'b0;
			crystal_stable       <= 1'b0;
			primary_in_gpio      <= 1'b0;
			primary_out_clkout   <= 1'b0;
			primary_out_gpio     <= 1'b0;
		end
		else
		begin
			active_source        <= src_q;
			internal_freq_select <= ifs_q;
			multiplier_enable    <= mult_on;
			internal_32mhz       <= want_32;
			hf_enable            <= hf_on;
			// the 16 MHz source is the loop locked onto the 500 kHz source
			hf_loop_enable       <= hf_on;
			mf_enable            <= mf_on || hf_on;
			fast_startup_active  <= hf_on && !hf_ready_s;
			hold_execution       <= hold_d;
			run_on_internal      <= run_int_d;
			crystal_stable       <= su_done;
			primary_in_gpio      <= internal_fuse;
			primary_out_clkout   <= rc_or_int && clock_out_pin_fuse;
			primary_out_gpio     <= rc_or_int && !clock_out_pin_fuse;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// an attempt at the release edge would judge outputs still held in reset
	logic live_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			live_q <= 1'b0;
		else
			live_q <= 1'b1;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !live_q);

	fuse_mult_a: assert property (
		fuse_multiplier_enable && src_q == SRC_FUSE && !wr_ctrl |=> multiplier_enable)
		else $error("fuse did not force multiplier on");

	soft_mult_a: assert property (
		wr_ctrl && pwdata[CTRL_SOFT_MULT] && pwdata[CTRL_SRC_LSB +: 2] == SRC_FUSE
		|=> ##1 multiplier_enable)
		else $error("software multiplier bit had no effect");

	mult_block_a: assert property (
		src_q[1] |=> !multiplier_enable)
		else $error("multiplier on with internal source select");

	hold_exec_a: assert property (
		su_busy && !bypass_hold |=> hold_execution && !run_on_internal)
		else $error("execution not held during start-up count");

	run_internal_a: assert property (
		su_busy && bypass_hold |=> run_on_internal && !hold_execution)
		else $error("internal clock not used during start-up count");

	hf_enable_a: assert property (
		hf_on |=> hf_enable && hf_loop_enable && mf_enable)
		else $error("16 MHz source not enabled");

	pin_release_a: assert property (
		internal_fuse |=> primary_in_gpio)
		else $error("primary input pin not released");

	clkout_pin_a: assert property (
		rc_or_int |=> (primary_out_clkout == !primary_out_gpio))
		else $error("second pin function not exclusive");

	wake_launch_a: assert property (
		crystal_mode && wake_rise |=> su_busy)
		else $error("wake-up did not relaunch start-up count");

	stat_read_a: assert property (
		access && !pwrite && sel_stat |=> prdata[STAT_HF_READY] == $past(hf_ready_s))
		else $error("ready flag read mismatch");

	su_done_c: cover property ($rose(crystal_stable));
	run_32_c:  cover property (internal_32mhz);
	second_c:  cover property (active_source == SRC_SECONDARY);
	unmap_c:   cover property (pslverr);

endmodule // scsc_top

`default_nettype wire

// ===== scsc_pkg.sv
// package: register map, field layout, fuse codes and counts for the clock source control
`default_nettype none

package scsc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
	localparam logic [7:0]  STAT_OFFSET    = 8'h04;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0038;

	// control register fields
	localparam int          CTRL_SRC_LSB   = 0;
	localparam int          CTRL_IFS_LSB   = 3;
	localparam int          CTRL_SOFT_MULT = 7;

	// status register fields
	localparam int          STAT_HF_STABLE = 0;
	localparam int          STAT_HF_LOCKED = 1;
	localparam int          STAT_MF_READY  = 3;
	localparam int          STAT_HF_READY  = 4;
	localparam int          STAT_XTAL_DONE = 5;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0]  SRC_FUSE       = 2'h0;
	localparam logic [1:0]  SRC_SECONDARY  = 2'h1;
	localparam logic [3:0]  IFS_RESET      = 4'h7;
	localparam logic [3:0]  IFS_32MHZ      = 4'hE;
	// which select codes run the 16 MHz source, which the 500 kHz one
	localparam logic [15:0] IFS_HF_CODES   = 16'hFF08;
	localparam logic [15:0] IFS_MF_CODES   = 16'h00F4;

	localparam logic [2:0]  MODE_WATCH     = 3'h0;
	localparam logic [2:0]  MODE_MEDIUM    = 3'h1;
	localparam logic [2:0]  MODE_HIGH      = 3'h2;
	localparam logic [2:0]  MODE_RC        = 3'h3;
	localparam logic [2:0]  MODE_INTERNAL  = 3'h4;

	// ------------------------------------------------------------
	// counts
	// ------------------------------------------------------------
	localparam int          STARTUP_COUNT  = 1024;
	localparam int          STARTUP_W      = 11;

	typedef enum logic [2:0] {
		SU_IDLE = 3'b001,
		SU_RUN  = 3'b010,
		SU_DONE = 3'b100
	} scsc_su_e;

endpackage

`default_nettype wire

// ===== scsc_sync.sv
// module: two flip-flop level synchroniser for asynchronous status inputs
`timescale 1ns/1ps
`default_nettype none

module scsc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // scsc_sync

`default_nettype wire

// ===== scsc_startup.sv
// module: crystal start-up counter, counts primary oscillator edges after a launch
`timescale 1ns/1ps
`default_nettype none

module scsc_startup
	import scsc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic launch,
	input  wire logic osc_edge,
	output logic      busy_q,
	output logic      done_q
);
	scsc_su_e               state_q;
	scsc_su_e               state_d;
	logic [STARTUP_W-1:0]   count_q;
	logic [STARTUP_W-1:0]   count_d;
	wire                    last_edge;

	localparam logic [STARTUP_W-1:0] LAST = STARTUP_W'(STARTUP_COUNT - 1);

	assign last_edge = osc_edge && (count_q == LAST);

	always_comb
	begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			SU_IDLE, SU_DONE:
				if (launch)
				begin
					state_d = SU_RUN;
					count_d = '0;
				end
			SU_RUN:
				if (launch)
					count_d = '0;
				else if (last_edge)
					state_d = SU_DONE;
				else if (osc_edge)
					count_d = count_q + STARTUP_W'(1);
			default:
				state_d = SU_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= SU_IDLE;
			count_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	assign busy_q = (state_q == SU_RUN);
	assign done_q = (state_q == SU_DONE);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// an attempt at the release edge would judge flops that were still in reset
	logic live_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			live_q <= 1'b0;
		else
			live_q <= 1'b1;
	end

	relaunch_clear_a: assert property (
		@(posedge pclk) disable iff (!presetn || !live_q)
		launch |=> (count_q == '0) && busy_q && !done_q)
		else $error("start-up count not cleared on launch");

	full_count_a: assert property (
		@(posedge pclk) disable iff (!presetn || !live_q)
		$rose(done_q) |-> $past(count_q) == LAST && $past(osc_edge))
		else $error("start-up done before full edge count");

endmodule // scsc_startup

`default_nettype wire

// ===== scsc_osc_model.sv
// far-side model: primary crystal and internal oscillator status lines
`timescale 1ns/1ps
`default_nettype none

module scsc_osc_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic osc_on,
	input  wire logic hf_enable,
	input  wire logic mf_enable,
	output logic      primary_clock_in_pin,
	output logic      hf_running,
	output logic      hf_within_2pct,
	output logic      hf_within_half_pct,
	output logic      mf_running,
	output int        rises
);
	int         hf_age;
	int         mf_age;
	logic [1:0] div_q;

	// ------------------------------------------------------------
	// crystal
	// ------------------------------------------------------------
	// swings at a quarter of pclk on the falling edge; stands low when unpowered
	always @(negedge pclk)
	begin
		if (!presetn || !osc_on)
		begin
			div_q = 2'h0;
			rises = presetn ? rises : 0;
			primary_clock_in_pin = 1'b0;
		end
		else
		begin
			div_q = div_q + 2'h1;
			if (div_q == 2'h2)
				rises = rises + 1;
			primary_clock_in_pin = div_q[1];
		end
	end

	// ------------------------------------------------------------
	// internal sources
	// ------------------------------------------------------------
	// flags settle after enable and drop at once; 500 kHz runs under the loop too
	always @(negedge pclk)
	begin
		hf_age = hf_enable ? hf_age + 1 : 0;
		mf_age = (mf_enable || hf_enable) ? mf_age + 1 : 0;
		hf_running = hf_age > 8;
		hf_within_2pct = hf_age > 16;
		hf_within_half_pct = hf_age > 24;
		mf_running = mf_age > 4;
	end
endmodule // scsc_osc_model

`default_nettype wire

// ===== testbench.sv
// testbench: directed scenarios for the clock source control
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
	begin \
		num_checks++; \
		if ((got) !== (ex)) \
		begin \
			errors++; \
			$display("BAD %s expected %0h seen %0h", nm, ex, got); \
		end \
	end

module testbench;
	import scsc_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr;
	logic [2:0]  fuse_osc_mode = MODE_INTERNAL;
	logic        fuse_multiplier_enable = 1'b0, clock_out_pin_fuse = 1'b1;
	logic        fuse_power_up_delay_en = 1'b0, fuse_clock_failure_monitor_en = 1'b0;
	logic        fuse_two_speed_en = 1'b0, power_up_delay_done = 1'b1, sleep_wake = 1'b0;
	logic        osc_on = 1'b0, primary_clock_in_pin;
	logic        hf_running, hf_within_2pct, hf_within_half_pct, mf_running;
	logic [1:0]  active_source;
	logic [3:0]  internal_freq_select;
	logic        multiplier_enable, internal_32mhz, hf_enable, mf_enable, hf_loop_enable;
	logic        fast_startup_active, hold_execution, run_on_internal, crystal_stable;
	logic        primary_in_gpio, primary_out_clkout, primary_out_gpio;
	int          rises, errors = 0, num_checks = 0;

	scsc_top i_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fuse_osc_mode, .fuse_multiplier_enable, .clock_out_pin_fuse,
		.fuse_power_up_delay_en, .fuse_clock_failure_monitor_en, .fuse_two_speed_en,
		.power_up_delay_done, .sleep_wake, .primary_clock_in_pin, .hf_running,
		.hf_within_2pct, .hf_within_half_pct, .mf_running, .active_source,
		.internal_freq_select, .multiplier_enable, .internal_32mhz, .hf_enable,
		.mf_enable, .hf_loop_enable, .fast_startup_active, .hold_execution,
		.run_on_internal, .crystal_stable, .primary_in_gpio, .primary_out_clkout,
		.primary_out_gpio
	);

	scsc_osc_model i_osc (
		.pclk, .presetn, .osc_on, .hf_enable, .mf_enable, .primary_clock_in_pin,
		.hf_running, .hf_within_2pct, .hf_within_half_pct, .mf_running, .rises
	);

	always #50 pclk = ~pclk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tmo(input bit ok);
		if (!ok)
		begin
			errors++;
			$display("BAD wait timed out");
			final_report();
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		tmo(n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
		repeat (3) @(posedge pclk);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex,
		input logic ee);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h0, rd, e);
		`CHK(nm, ex, rd)
		`CHK("pslverr", ee, e)
	endtask

	task automatic reset_dut(input logic [2:0] m);
		@(posedge pclk);
		fuse_osc_mode <= m;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		reset_dut(MODE_INTERNAL);
		rd_chk("ctrl", CTRL_OFFSET, CTRL_RESET, 1'b0);
		`CHK("ifs", IFS_RESET, internal_freq_select)
		`CHK("src", SRC_FUSE, active_source)
		`CHK("mf_en", 1'b1, mf_enable)
		`CHK("in_gpio", 1'b1, primary_in_gpio)
		`CHK("clkout", 1'b1, primary_out_clkout)
		`CHK("xtal", 1'b0, crystal_stable)
		rd_chk("hole", 8'h08, 32'h0, 1'b1);
		wr(8'h0C, 32'h0);
		wr(STAT_OFFSET, 32'hFF);
		rd_chk("ctrl2", CTRL_OFFSET, CTRL_RESET, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_freq(input logic [2:0] m, input logic [1:0] s);
		logic on;
		clock_out_pin_fuse <= 1'b0;
		reset_dut(m);
		on = (m == MODE_INTERNAL) || s[1];
		repeat (3) @(posedge pclk);
		`CHK("out_gpio", 1'b1, primary_out_gpio)
		`CHK("in_gpio", m == MODE_INTERNAL, primary_in_gpio)
		for (int c = 0; c < 16; c++)
		begin
			wr(CTRL_OFFSET, {24'h0, 1'b0, c[3:0], 1'b0, s});
			`CHK("ifs", c[3:0], internal_freq_select)
			`CHK("src", s, active_source)
			`CHK("hf_en", on & IFS_HF_CODES[c], hf_enable)
			`CHK("loop", on & IFS_HF_CODES[c], hf_loop_enable)
			`CHK("mf_en", on & (IFS_HF_CODES[c] | IFS_MF_CODES[c]), mf_enable)
		end
		$display("test freq done");
	endtask

	task automatic t_mult();
		logic [10:0] tbl [6] = '{11'h3C3, 11'h1C0, 11'h5C3, 11'h5C8, 11'h3C4, 11'h3A2};
		reset_dut(MODE_INTERNAL);
		for (int i = 0; i < 6; i++)
		begin
			fuse_multiplier_enable <= tbl[i][10];
			wr(CTRL_OFFSET, {24'h0, tbl[i][9:2]});
			`CHK("mult", tbl[i][1], multiplier_enable)
			`CHK("m32", tbl[i][0], internal_32mhz)
		end
		fuse_multiplier_enable <= 1'b0;
		$display("test multiplier done");
	endtask

	task automatic t_status();
		reset_dut(MODE_INTERNAL);
		wr(CTRL_OFFSET, 32'h78);
		`CHK("fast", 1'b1, fast_startup_active)
		repeat (60) @(posedge pclk);
		`CHK("fast_end", 1'b0, fast_startup_active)
		rd_chk("stat", STAT_OFFSET, 32'h1B, 1'b0);
		wr(CTRL_OFFSET, 32'h10);
		repeat (20) @(posedge pclk);
		rd_chk("stat_mf", STAT_OFFSET, 32'h08, 1'b0);
		$display("test status done");
	endtask

	task automatic t_xtal(input logic [2:0] m, input logic mon, input logic ts);
		int n;
		int base;
		fuse_clock_failure_monitor_en <= mon;
		fuse_two_speed_en <= ts;
		osc_on <= 1'b1;
		reset_dut(m);
		repeat (4) @(posedge pclk);
		`CHK("hold", ~(mon | ts), hold_execution)
		`CHK("run_int", mon | ts, run_on_internal)
		for (n = 0; n < 6000 && rises < 1020; n++)
			@(posedge pclk);
		tmo(n < 6000);
		`CHK("early", 1'b0, crystal_stable)
		for (n = 0; n < 100 && crystal_stable !== 1'b1; n++)
			@(posedge pclk);
		tmo(n < 100);
		`CHK("count", 1'b1, rises >= 1024 && rises <= 1026)
		`CHK("hold_end", 1'b0, hold_execution | run_on_internal)
		// second wake lands mid-count, so the count must start over
		for (int k = 0; k < 2; k++)
		begin
			base = rises;
			sleep_wake <= 1'b1;
			repeat (6) @(posedge pclk);
			sleep_wake <= 1'b0;
			`CHK("relaunch", 1'b0, crystal_stable)
			for (n = 0; n < 4400 && crystal_stable !== 1'b1 && (k == 1 || rises - base < 500); n++)
				@(posedge pclk);
			tmo(n < 4400);
		end
		`CHK("recount", 1'b1, rises - base >= 1024 && rises - base <= 1028)
		$display("test start-up done");
	endtask

	task automatic t_power_up_delay_timer();
		fuse_power_up_delay_en <= 1'b1;
		power_up_delay_done <= 1'b0;
		reset_dut(MODE_WATCH);
		repeat (20) @(posedge pclk);
		`CHK("wait_power_up_delay_timer", 1'b0, hold_execution)
		power_up_delay_done <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK("go_power_up_delay_timer", 1'b1, hold_execution)
		fuse_power_up_delay_en <= 1'b0;
		$display("test power-up done");
	endtask

	initial
	begin
		t_reset();
		t_freq(MODE_INTERNAL, 2'h0);
		t_freq(MODE_RC, 2'h0);
		t_freq(MODE_RC, 2'h1);
		t_freq(MODE_RC, 2'h2);
		t_mult();
		t_status();
		t_xtal(MODE_MEDIUM, 1'b0, 1'b0);
		t_power_up_delay_timer();
		t_xtal(MODE_HIGH, 1'b1, 1'b0);
		t_xtal(MODE_WATCH, 1'b0, 1'b1);
		final_report();
	end
endmodule // testbench

`default_nettype wire
